// [dsf_pkg.sv]
/*
  Shared constants, types and register map of the drive speed status flags block.
  Assumes a single 20 MHz clock domain and AHB-Lite register access.
*/
`default_nettype none

package dsf_pkg;

  // Value widths and terminal count
  localparam int VAL_W = 16;
  localparam int SEL_W = 8;
  localparam int N_TERM = 3;

  // Register byte offsets
  localparam logic [11:0] ADDR_CTRL = 12'h000;
  localparam logic [11:0] ADDR_ZERO_THR = 12'h004;
  localparam logic [11:0] ADDR_DEV_THR = 12'h008;
  localparam logic [11:0] ADDR_TERM_SEL = 12'h00c;
  localparam logic [11:0] ADDR_FLAGS = 12'h010;
  localparam logic [11:0] ADDR_IRQ_STAT = 12'h014;
  localparam logic [11:0] ADDR_IRQ_MASK = 12'h018;

  // Field positions
  localparam int CTRL_ENC_BIT = 0;
  localparam int FLG_ZERO_BIT = 0;
  localparam int FLG_DEV_BIT = 1;
  localparam int FLG_TERM_LSB = 2;

  // Reset values
  localparam logic [VAL_W-1:0] ZERO_THR_RST = 16'h0000;
  localparam logic [VAL_W-1:0] DEV_THR_RST = 16'h0000;
  localparam logic [SEL_W-1:0] TERM_SEL_RST = 8'h00;
  localparam logic CTRL_ENC_RST = 1'b0;

  // Terminal function codes
  localparam logic [SEL_W-1:0] CODE_ZERO = 8'h15;
  localparam logic [SEL_W-1:0] CODE_DEV = 8'h37;
  localparam logic [SEL_W-1:0] CODE_DEV_ALT = 8'h16;

  typedef struct packed {
    logic dev;
    logic zero;
  } dsf_flags_s;

  typedef enum logic [1:0] {
    BUS_IDLE = 2'b01,
    BUS_RDWAIT = 2'b10
  } dsf_bus_e;

endpackage

`default_nettype wire

// [dsf_top.sv]
/*
  Zero-speed and speed-deviation flags with terminal routing, AHB-Lite registers
  and a masked interrupt.
  Assumes drive frequency and speed inputs come from logic on the same clock.
*/
// Notes on behaviour
// - Zero-speed flag high while output frequency is below its threshold.
// - Terminal shows zero-speed flag only when its selection holds code 21.
// - Deviation flag on when gap below threshold, off when above.
// - Deviation flag evaluated only with encoder feedback connected.
// - Terminal shows deviation flag when selection holds code 55 or 22.
`timescale 1ns/1ns
`default_nettype none

module dsf_top
  import dsf_pkg::*;
#(
  parameter int VW = VAL_W,
  parameter int NT = N_TERM
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic [31:0] hrdata,
  output logic hreadyout,
  output logic hresp,
  input wire logic [VW-1:0] out_freq,
  input wire logic [VW-1:0] speed_cmd,
  input wire logic [VW-1:0] speed_meas,
  output logic zero_speed_flag,
  output logic speed_deviation_flag,
  output logic [NT-1:0] term_out,
  output logic irq
);

  generate
    if (VW < 1 || VW > 16 || NT < 1 || NT > 4) begin : g_bad_param
      $error("dsf_top: VW must be 1..16 and NT 1..4");
    end
  endgenerate

  // Bus state
  dsf_bus_e bus_ff, nxt_bus;
  logic wr_pend_ff, nxt_wr_pend;
  logic [11:0] addr_ff, nxt_addr;
  logic [31:0] hrdata_ff, nxt_hrdata;
  logic hready_ff, nxt_hready;

  // Register state
  logic enc_ff, nxt_enc;
  logic [VW-1:0] zero_thr_ff, nxt_zero_thr;
  logic [VW-1:0] dev_thr_ff, nxt_dev_thr;
  logic [NT-1:0][SEL_W-1:0] sel_ff, nxt_sel;
  dsf_flags_s stat_ff, nxt_stat;
  dsf_flags_s mask_ff, nxt_mask;

  // Flag state
  dsf_flags_s flg_ff, nxt_flg;
  logic [NT-1:0] term_ff, nxt_term;
  logic irq_ff, nxt_irq;
  logic [VW-1:0] gap;
  logic zero_d_ff, dev_d_ff;

  logic take;
  assign take = hsel && htrans[1] && hready;

  function automatic logic [31:0] rd_mux(input logic [11:0] a);
    logic [31:0] d;
    d = 32'h0000_0000;
    if (a == ADDR_CTRL) begin
      d[CTRL_ENC_BIT] = enc_ff;
    end else if (a == ADDR_ZERO_THR) begin
      d[VW-1:0] = zero_thr_ff;
    end else if (a == ADDR_DEV_THR) begin
      d[VW-1:0] = dev_thr_ff;
    end else if (a == ADDR_TERM_SEL) begin
      d[NT*SEL_W-1:0] = sel_ff;
    end else if (a == ADDR_FLAGS) begin
      d[FLG_ZERO_BIT] = flg_ff.zero;
      d[FLG_DEV_BIT] = flg_ff.dev;
      d[FLG_TERM_LSB +: NT] = term_ff;
    end else if (a == ADDR_IRQ_STAT) begin
      d[1:0] = stat_ff;
    end else if (a == ADDR_IRQ_MASK) begin
      d[1:0] = mask_ff;
    end
    return d;
  endfunction

  // Reads take one wait state so the word is fetched after any prior write lands
  always_comb begin
    nxt_bus = bus_ff;
    nxt_wr_pend = 1'b0;
    nxt_addr = addr_ff;
    nxt_hrdata = hrdata_ff;
    nxt_hready = 1'b1;
    case (bus_ff)
      BUS_IDLE: begin
        if (take) begin
          nxt_addr = {haddr[11:2], 2'b00};
          if (hwrite) begin
            nxt_wr_pend = 1'b1;
          end else begin
            nxt_bus = BUS_RDWAIT;
            nxt_hready = 1'b0;
          end
        end
      end
      BUS_RDWAIT: begin
        nxt_hrdata = rd_mux(addr_ff);
        nxt_bus = BUS_IDLE;
      end
      default: begin
        nxt_bus = BUS_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      bus_ff <= BUS_IDLE;
      wr_pend_ff <= 1'b0;
      addr_ff <= 12'h000;
      hrdata_ff <= 32'h0000_0000;
      hready_ff <= 1'b1;
    end else begin
      bus_ff <= nxt_bus;
      wr_pend_ff <= nxt_wr_pend;
      addr_ff <= nxt_addr;
      hrdata_ff <= nxt_hrdata;
      hready_ff <= nxt_hready;
    end
  end

  // Flag comparisons and register writes
  always_comb begin
    nxt_enc = enc_ff;
    nxt_zero_thr = zero_thr_ff;
    nxt_dev_thr = dev_thr_ff;
    nxt_sel = sel_ff;
    nxt_mask = mask_ff;
    nxt_stat = stat_ff;
    gap = (speed_cmd >= speed_meas) ? speed_cmd - speed_meas : speed_meas - speed_cmd;
    nxt_flg.zero = out_freq < zero_thr_ff;
    // Equal gap keeps the last state; the two edges are stated separately
    if (!enc_ff) begin
      nxt_flg.dev = 1'b0;
    end else if (gap < dev_thr_ff) begin
      nxt_flg.dev = 1'b1;
    end else if (gap > dev_thr_ff) begin
      nxt_flg.dev = 1'b0;
    end else begin
      nxt_flg.dev = flg_ff.dev;
    end
    if (wr_pend_ff) begin
      if (addr_ff == ADDR_CTRL) begin
        nxt_enc = hwdata[CTRL_ENC_BIT];
      end else if (addr_ff == ADDR_ZERO_THR) begin
        nxt_zero_thr = hwdata[VW-1:0];
      end else if (addr_ff == ADDR_DEV_THR) begin
        nxt_dev_thr = hwdata[VW-1:0];
      end else if (addr_ff == ADDR_TERM_SEL) begin
        nxt_sel = hwdata[NT*SEL_W-1:0];
      end else if (addr_ff == ADDR_IRQ_STAT) begin
        nxt_stat = stat_ff & ~hwdata[1:0];
      end else if (addr_ff == ADDR_IRQ_MASK) begin
        nxt_mask = hwdata[1:0];
      end
    end
    // Rising edges set sticky bits; a set beats a same-cycle clear
    nxt_stat.zero = nxt_stat.zero | (flg_ff.zero & ~zero_d_ff);
    nxt_stat.dev = nxt_stat.dev | (flg_ff.dev & ~dev_d_ff);
    nxt_irq = |(stat_ff & mask_ff);
  end

  genvar gi;
  generate
    for (gi = 0; gi < NT; gi++) begin : g_term
      always_comb begin
        nxt_term[gi] = ((sel_ff[gi] == CODE_ZERO) && flg_ff.zero) ||
          (((sel_ff[gi] == CODE_DEV) || (sel_ff[gi] == CODE_DEV_ALT)) && flg_ff.dev);
      end
    end
  endgenerate

  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      enc_ff <= CTRL_ENC_RST;
      zero_thr_ff <= ZERO_THR_RST[VW-1:0];
      dev_thr_ff <= DEV_THR_RST[VW-1:0];
      sel_ff <= {NT{TERM_SEL_RST}};
      stat_ff <= '0;
      mask_ff <= '0;
      flg_ff <= '0;
      zero_d_ff <= 1'b0;
      dev_d_ff <= 1'b0;
      term_ff <= '0;
      irq_ff <= 1'b0;
    end else begin
      enc_ff <= nxt_enc;
      zero_thr_ff <= nxt_zero_thr;
      dev_thr_ff <= nxt_dev_thr;
      sel_ff <= nxt_sel;
      stat_ff <= nxt_stat;
      mask_ff <= nxt_mask;
      flg_ff <= nxt_flg;
      zero_d_ff <= flg_ff.zero;
      dev_d_ff <= flg_ff.dev;
      term_ff <= nxt_term;
      irq_ff <= nxt_irq;
    end
  end

  assign hrdata = hrdata_ff;
  assign hreadyout = hready_ff;
  assign hresp = 1'b0;
  assign zero_speed_flag = flg_ff.zero;
  assign speed_deviation_flag = flg_ff.dev;
  assign term_out = term_ff;
  assign irq = irq_ff;

  // Checks
  sequence s_rd_addr;
    take && !hwrite && (bus_ff == BUS_IDLE);
  endsequence

  sequence s_rd_wait;
    !hreadyout ##1 hreadyout;
  endsequence

  a_zero_compare: assert property (@(posedge clk) disable iff (rst)
    zero_speed_flag == $past(out_freq < zero_thr_ff))
    else $error("zero-speed flag does not match comparison");

  a_dev_set: assert property (@(posedge clk) disable iff (rst)
    (enc_ff && gap < dev_thr_ff) |=> speed_deviation_flag)
    else $error("deviation flag not set below threshold");

  a_dev_clear: assert property (@(posedge clk) disable iff (rst)
    (gap > dev_thr_ff) |=> !speed_deviation_flag)
    else $error("deviation flag not cleared above threshold");

  a_dev_no_enc: assert property (@(posedge clk) disable iff (rst)
    !enc_ff |=> !speed_deviation_flag)
    else $error("deviation flag set without encoder");

  a_term_zero: assert property (@(posedge clk) disable iff (rst)
    (sel_ff[0] == CODE_ZERO && $stable(sel_ff)) |=> (term_out[0] == $past(zero_speed_flag)))
    else $error("terminal 0 does not follow zero-speed flag");

  a_term_dev: assert property (@(posedge clk) disable iff (rst)
    (sel_ff[0] == CODE_DEV && $stable(sel_ff)) |=> (term_out[0] == $past(speed_deviation_flag)))
    else $error("terminal 0 does not follow deviation flag");

  a_zero_follow: assert property (@(posedge clk) disable iff (rst)
    (out_freq >= zero_thr_ff) |=> !zero_speed_flag)
    else $error("zero-speed flag latched above threshold");

  a_dev_hold: assert property (@(posedge clk) disable iff (rst)
    (enc_ff && gap == dev_thr_ff) |=> (speed_deviation_flag == $past(speed_deviation_flag)))
    else $error("deviation flag changed at equal gap");

  a_read_wait: assert property (@(posedge clk) disable iff (rst)
    s_rd_addr |=> s_rd_wait)
    else $error("read data phase not one wait state");

  a_irq_level: assert property (@(posedge clk) disable iff (rst)
    |(stat_ff & mask_ff) |=> irq)
    else $error("interrupt not raised for unmasked status");

endmodule // dsf_top

`default_nettype wire

// [dsf_relay_model.sv]
/*
  Relay coil model at the far side of the routed terminal outputs.
  Assumes term_out is driven on the same clock as this model.
*/
`timescale 1ns/1ns
`default_nettype none

module dsf_relay_model
  import dsf_pkg::*;
#(
  parameter int NT = N_TERM
) (
  input wire logic clk,
  input wire logic rst,
  input wire logic [NT-1:0] term_out,
  output logic [NT-1:0] coil_on
);
  // Coil follows its terminal one edge late, like a slow load
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      coil_on <= '0;
    end else begin
      coil_on <= term_out;
    end
  end
endmodule // dsf_relay_model

`default_nettype wire

// [dsf_top_tb_top.sv]
/*
  Self-checking bench: AHB-Lite register tasks, flag and terminal scenarios.
  Assumes dsf_pkg, dsf_top and dsf_relay_model are compiled first.
*/
`timescale 1ns/1ns
`default_nettype none

module dsf_top_tb_top;
  import dsf_pkg::*;
  logic clk, rst, hsel, hwrite, hready, hreadyout, hresp, irq, zsf, devf;
  logic [31:0] haddr, hwdata, hrdata, rv;
  logic [1:0] htrans;
  logic [2:0] hsize, term_out, coil_on;
  logic [15:0] out_freq, speed_cmd, speed_meas;
  int n_errors, n_tests;
  assign hready = hreadyout;

  dsf_top i_dsf_top (.clk(clk), .rst(rst), .hsel(hsel), .haddr(haddr), .htrans(htrans),
    .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready), .hrdata(hrdata),
    .hreadyout(hreadyout), .hresp(hresp), .out_freq(out_freq), .speed_cmd(speed_cmd),
    .speed_meas(speed_meas), .zero_speed_flag(zsf), .speed_deviation_flag(devf),
    .term_out(term_out), .irq(irq));
  dsf_relay_model i_dsf_relay_model (.clk(clk), .rst(rst), .term_out(term_out),
    .coil_on(coil_on));

  initial begin
    clk = 0;
    forever #25 clk = ~clk;
  end

  task automatic chk(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_tests++;
    if (g !== e) begin
      n_errors++;
      $display("mismatch %s exp %h got %h", nm, e, g);
    end
  endtask

  // Master waits on hready only; no latency assumed
  task automatic bus(input logic w, input logic [11:0] a, input logic [31:0] d);
    hsel <= 1;
    htrans <= 2'b10;
    hwrite <= w;
    haddr <= {20'h0, a};
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    hsel <= 0;
    htrans <= 2'b00;
    hwdata <= d;
    @(posedge clk);
    while (hready !== 1'b1) @(posedge clk);
    rv = hrdata;
    chk("hresp", 32'h0, 32'(hresp));
  endtask

  task automatic wr(input logic [11:0] a, input logic [31:0] d);
    bus(1, a, d);
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] e);
    bus(0, a, 32'h0);
    chk($sformatf("reg %h", a), e, rv);
  endtask

  task automatic settle;
    repeat (4) @(posedge clk);
  endtask

  task automatic flags(input logic z, input logic v, input logic [2:0] t);
    chk("zero", 32'(z), 32'(zsf));
    chk("dev", 32'(v), 32'(devf));
    chk("term", 32'(t), 32'(term_out));
    chk("coil", 32'(t), 32'(coil_on));
  endtask

  task automatic t_regs;
    rd(ADDR_CTRL, 32'h0);
    rd(ADDR_ZERO_THR, 32'h0);
    rd(ADDR_DEV_THR, 32'h0);
    rd(ADDR_TERM_SEL, 32'h0);
    rd(ADDR_IRQ_MASK, 32'h0);
    wr(ADDR_DEV_THR, 32'h0000abcd);
    rd(ADDR_DEV_THR, 32'h0000abcd);
    wr(12'h01c, 32'hffffffff);
    rd(12'h01c, 32'h0);
    $display("t_regs done");
  endtask

  task automatic t_zero;
    logic [15:0] v [4];
    v = '{16'h0063, 16'h0064, 16'h0065, 16'h0063};
    wr(ADDR_ZERO_THR, 32'h00000064);
    wr(ADDR_TERM_SEL, {16'h0, CODE_DEV, CODE_ZERO});
    // Encoder off, so the deviation terminal stays low
    foreach (v[i]) begin
      out_freq <= v[i];
      settle;
      flags(v[i] < 16'h0064, 1'b0, {2'b00, v[i] < 16'h0064});
    end
    $display("t_zero done");
  endtask

  task automatic t_dev;
    wr(ADDR_DEV_THR, 32'h0000000a);
    wr(ADDR_TERM_SEL, {8'h00, CODE_ZERO, CODE_DEV_ALT, CODE_DEV});
    speed_cmd <= 16'h01f4;
    speed_meas <= 16'h01ef;
    settle;
    flags(1'b1, 1'b0, 3'b100);
    wr(ADDR_CTRL, 32'h1);
    settle;
    flags(1'b1, 1'b1, 3'b111);
    speed_meas <= 16'h01e0;
    settle;
    flags(1'b1, 1'b0, 3'b100);
    speed_meas <= 16'h01f3;
    settle;
    flags(1'b1, 1'b1, 3'b111);
    rd(ADDR_FLAGS, 32'h0000001f);
    // Gap equal to threshold keeps the last state, from either side
    speed_meas <= 16'h01fe;
    settle;
    flags(1'b1, 1'b1, 3'b111);
    speed_meas <= 16'h0200;
    settle;
    flags(1'b1, 1'b0, 3'b100);
    speed_meas <= 16'h01ea;
    settle;
    flags(1'b1, 1'b0, 3'b100);
    $display("t_dev done");
  endtask

  task automatic t_irq;
    wr(ADDR_IRQ_STAT, 32'h3);
    out_freq <= 16'h00c8;
    settle;
    out_freq <= 16'h0032;
    settle;
    rd(ADDR_IRQ_STAT, 32'h1);
    chk("irq", 32'h0, 32'(irq));
    wr(ADDR_IRQ_MASK, 32'h1);
    settle;
    chk("irq", 32'h1, 32'(irq));
    wr(ADDR_IRQ_STAT, 32'h1);
    settle;
    chk("irq", 32'h0, 32'(irq));
    rd(ADDR_IRQ_STAT, 32'h0);
    // Deviation event sets its own bit; masked, so no interrupt
    speed_meas <= 16'h01f3;
    settle;
    rd(ADDR_IRQ_STAT, 32'h2);
    chk("irq", 32'h0, 32'(irq));
    $display("t_irq done");
  endtask

  task automatic summarize;
    $display("tests %0d mismatches %0d", n_tests, n_errors);
    if (n_errors == 0 && n_tests > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  initial begin
    rst = 1;
    {hsel, hwrite, htrans, haddr, hwdata} = '0;
    hsize = 3'b010;
    {out_freq, speed_cmd, speed_meas} = '0;
    repeat (5) @(posedge clk);
    rst <= 0;
    @(posedge clk);
    t_regs;
    t_zero;
    t_dev;
    t_irq;
    summarize;
  end

  // Whole run is under two hundred cycles
  initial begin
    repeat (5000) @(posedge clk);
    n_errors++;
    summarize;
  end
endmodule // dsf_top_tb_top

`default_nettype wire
